// file: sfr_top.sv
// Fastlock timing and denominator width of the main synthesizer loop; counter-reset control of main and auxiliary loops
`timescale 1ns/1ps
`include "sfr_regs.svh"
module sfr_top
	import sfr_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// Serial programming pins
	input wire logic ser_clk_i,
	input wire logic ser_data_i,
	input wire logic ser_le_i,
	// Denominator inputs from neighbouring words
	input wire logic resolution_sel_i,
	input wire logic [11:0] den_low_i,
	// Loop events and power control
	input wire logic pd_cycle_i,
	input wire logic aux_pd_cycle_i,
	input wire logic fastlock_start_i,
	input wire logic sw_powerdown_i,
	input wire logic chip_enable_i,
	// Fractional denominator
	output logic [21:0] fractional_denominator_o,
	// Fastlock
	output logic fastlock_active_o,
	output logic force_fastlock_o,
	output logic fastlock_indicator_pin_o,
	output logic fastlock_indicator_pin_oe_o,
	output logic [4:0] fastlock_pump_current_o,
	output logic [2:0] cycle_slip_reduction_o,
	// Lock detect
	output logic main_ld_cycle_o,
	output logic aux_ld_cycle_o,
	// Counter resets and pump tri-state
	output logic main_counter_reset_o,
	output logic aux_counter_reset_o,
	output logic main_pump_tristate_o,
	output logic aux_pump_tristate_o
);
	logic [`SFR_WORD_W-1:0] word;
	logic word_valid;
	logic [3:0] word_addr;
	logic [9:0] den_hi_q;
	logic [13:0] fastlock_timeout_value_q;
	logic [3:0] pump_code_q;
	logic [1:0] slip_code_q;
	logic lock_detect_prescale_q;
	logic main_counter_reset_q;
	logic aux_counter_reset_q;
	logic main_tri_q;
	logic aux_tri_q;
	logic [1:0] ce_sync_q;
	logic powered_q;
	logic powerup_q;
	logic powered;
	logic timed_en;
	sfr_fl_state_t fl_state_q;
	logic [14:0] fl_cnt_q;
	sfr_pin_mode_t pin_mode;
	logic [1:0] pre_cnt_q;
	logic main_ld_q;
	logic aux_ld_q;

	sfr_serial_rx u_rx (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.ser_clk_i(ser_clk_i),
		.ser_data_i(ser_data_i),
		.ser_le_i(ser_le_i),
		.word_o(word),
		.word_valid_o(word_valid)
	);
	assign word_addr = word[`SFR_ADDR_MSB:`SFR_ADDR_LSB];
	// Denominator upper bits
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			den_hi_q <= `SFR_DEN_HI_RST;
		end else if (word_valid && word_addr == `SFR_ADDR_DEN) begin
			den_hi_q <= word[`SFR_DEN_HI_MSB:`SFR_DEN_HI_LSB];
		end
	end
	// Fastlock timing word
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			fastlock_timeout_value_q <= `SFR_TOC_RST;
			pump_code_q <= `SFR_CPF_RST;
			slip_code_q <= `SFR_CSR_RST;
		end else if (word_valid && word_addr == `SFR_ADDR_FL) begin
			fastlock_timeout_value_q <= word[`SFR_TOC_MSB:`SFR_TOC_LSB];
			pump_code_q <= word[`SFR_CPF_MSB:`SFR_CPF_LSB];
			slip_code_q <= word[`SFR_CSR_MSB:`SFR_CSR_LSB];
		end
	end
	// Lock-detect and reset word
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			lock_detect_prescale_q <= 1'b0;
			aux_counter_reset_q <= 1'b0;
			main_counter_reset_q <= 1'b0;
			aux_tri_q <= 1'b0;
			main_tri_q <= 1'b0;
		end else if (word_valid && word_addr == `SFR_ADDR_CTL) begin
			lock_detect_prescale_q <= word[`SFR_CTL_PRESCALE_BIT];
			aux_counter_reset_q <= word[`SFR_CTL_AUX_RST_BIT];
			main_counter_reset_q <= word[`SFR_CTL_MAIN_RST_BIT];
			aux_tri_q <= word[`SFR_CTL_AUX_TRI_BIT];
			main_tri_q <= word[`SFR_CTL_MAIN_TRI_BIT];
		end
	end
	// Denominator width select
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			fractional_denominator_o <= '0;
		end else if (resolution_sel_i) begin
			fractional_denominator_o <= {den_hi_q, den_low_i};
		end else begin
			fractional_denominator_o <= {10'h000, den_low_i};
		end
	end
	// Chip-enable pin synchroniser and power-up detect
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ce_sync_q <= 2'h0;
			powered_q <= 1'b0;
			powerup_q <= 1'b0;
		end else begin
			ce_sync_q <= {ce_sync_q[0], chip_enable_i};
			powered_q <= powered;
			powerup_q <= powered & ~powered_q;
		end
	end
	assign powered = ce_sync_q[1] & ~sw_powerdown_i;
	assign timed_en = fastlock_timeout_value_q >= `SFR_TOC_MIN_TIMED;
	// Fastlock timer in comparison cycles
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			fl_state_q <= FL_IDLE;
			fl_cnt_q <= 15'h0000;
		end else begin
			case (fl_state_q)
				FL_IDLE: begin
					if (fastlock_start_i && timed_en) begin
						fl_state_q <= FL_ACTIVE;
						fl_cnt_q <= {fastlock_timeout_value_q, 1'b0};
					end
				end
				FL_ACTIVE: begin
					if (!timed_en) begin
						fl_state_q <= FL_IDLE;
						fl_cnt_q <= 15'h0000;
					end else if (pd_cycle_i) begin
						fl_cnt_q <= fl_cnt_q - 15'h0001;
						if (fl_cnt_q == 15'h0001) begin
							fl_state_q <= FL_IDLE;
						end
					end
				end
				default: begin
					fl_state_q <= FL_IDLE;
					fl_cnt_q <= 15'h0000;
				end
			endcase
		end
	end
	// Pin function from time-out value
	always_comb begin
		case (fastlock_timeout_value_q)
			`SFR_TOC_HIZ: pin_mode = PIN_HIZ;
			`SFR_TOC_MANUAL: pin_mode = PIN_MANUAL;
			`SFR_TOC_LOW: pin_mode = PIN_LOW;
			`SFR_TOC_HIGH: pin_mode = PIN_HIGH;
			default: pin_mode = PIN_FASTLOCK;
		endcase
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			fastlock_indicator_pin_o <= 1'b0;
			fastlock_indicator_pin_oe_o <= 1'b0;
			force_fastlock_o <= 1'b0;
		end else begin
			force_fastlock_o <= pin_mode == PIN_MANUAL;
			fastlock_indicator_pin_oe_o <= pin_mode != PIN_HIZ;
			case (pin_mode)
				PIN_HIGH: fastlock_indicator_pin_o <= 1'b1;
				PIN_FASTLOCK: fastlock_indicator_pin_o <= fl_state_q == FL_ACTIVE;
				default: fastlock_indicator_pin_o <= 1'b0;
			endcase
		end
	end
	assign fastlock_active_o = fl_state_q == FL_ACTIVE;
	// Pump current and slip reduction
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			fastlock_pump_current_o <= 5'h01;
			cycle_slip_reduction_o <= `SFR_CSR_SHIFT_OFF;
		end else begin
			fastlock_pump_current_o <= {1'b0, pump_code_q} + 5'h01;
			case (slip_code_q)
				`SFR_CSR_OFF: cycle_slip_reduction_o <= `SFR_CSR_SHIFT_OFF;
				`SFR_CSR_HALF: cycle_slip_reduction_o <= `SFR_CSR_SHIFT_HALF;
				`SFR_CSR_QUARTER: cycle_slip_reduction_o <= `SFR_CSR_SHIFT_QUARTER;
				default: cycle_slip_reduction_o <= `SFR_CSR_SHIFT_SIXTEENTH;
			endcase
		end
	end
	// Lock-detect prescaler, main loop only
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pre_cnt_q <= 2'h0;
			main_ld_q <= 1'b0;
			aux_ld_q <= 1'b0;
		end else begin
			aux_ld_q <= aux_pd_cycle_i;
			if (pd_cycle_i) begin
				pre_cnt_q <= pre_cnt_q + 2'h1;
			end
			main_ld_q <= pd_cycle_i && (!lock_detect_prescale_q || pre_cnt_q == `SFR_PRESCALE_LAST);
		end
	end
	assign main_ld_cycle_o = main_ld_q;
	assign aux_ld_cycle_o = aux_ld_q;
	// Counter resets and pump tri-state
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			main_counter_reset_o <= 1'b1;
			aux_counter_reset_o <= 1'b1;
			main_pump_tristate_o <= 1'b1;
			aux_pump_tristate_o <= 1'b1;
		end else begin
			main_counter_reset_o <= main_counter_reset_q | powerup_q;
			aux_counter_reset_o <= aux_counter_reset_q | powerup_q;
			main_pump_tristate_o <= main_counter_reset_q | main_tri_q | powerup_q;
			aux_pump_tristate_o <= aux_counter_reset_q | aux_tri_q | powerup_q;
		end
	end
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	a_den_narrow: assert property (!resolution_sel_i |=> fractional_denominator_o[21:12] == 10'h000)
		else $error("upper denominator bits not masked");
	a_den_wide: assert property (resolution_sel_i |=> fractional_denominator_o == {$past(den_hi_q), $past(den_low_i)})
		else $error("wide denominator wrong");
	a_fl_disabled: assert property (!timed_en |=> !fastlock_active_o)
		else $error("fastlock active with small time-out");
	a_fl_start_load: assert property (fl_state_q == FL_IDLE && fastlock_start_i && timed_en |=>
		fastlock_active_o && fl_cnt_q == {$past(fastlock_timeout_value_q), 1'b0})
		else $error("fastlock did not load twice the time-out");
	a_fl_count_step: assert property (fastlock_active_o && timed_en && pd_cycle_i && fl_cnt_q > 15'h0001 |=>
		fastlock_active_o && fl_cnt_q == $past(fl_cnt_q) - 15'h0001)
		else $error("fastlock count step wrong");
	a_fl_hold: assert property (fastlock_active_o && !pd_cycle_i |=> fastlock_active_o || !$past(timed_en))
		else $error("fastlock ended without comparison cycle");
	a_pin_hiz: assert property (fastlock_timeout_value_q == `SFR_TOC_HIZ [*2] |-> !fastlock_indicator_pin_oe_o)
		else $error("pin driven in hi-Z mode");
	a_pin_manual: assert property (fastlock_timeout_value_q == `SFR_TOC_MANUAL [*2] |->
		force_fastlock_o && fastlock_indicator_pin_oe_o && !fastlock_indicator_pin_o)
		else $error("manual fastlock pin wrong");
	a_pin_high: assert property (fastlock_timeout_value_q == `SFR_TOC_HIGH [*2] |->
		fastlock_indicator_pin_oe_o && fastlock_indicator_pin_o)
		else $error("pin not high");
	a_pump_mult: assert property (##1 fastlock_pump_current_o == {1'b0, $past(pump_code_q)} + 5'h01)
		else $error("pump multiple wrong");
	a_prescale_gap: assert property (lock_detect_prescale_q [*4] ##0 main_ld_cycle_o |-> !$past(main_ld_cycle_o))
		else $error("prescaled lock-detect pulses adjacent");
	a_main_reset: assert property (main_counter_reset_q |=> main_counter_reset_o && main_pump_tristate_o)
		else $error("main counters not held in reset");
	a_aux_reset: assert property (aux_counter_reset_q |=> aux_counter_reset_o && aux_pump_tristate_o)
		else $error("aux counters not held in reset");
	a_powerup_reset: assert property ($rose(powered) |-> ##2 main_counter_reset_o && aux_counter_reset_o)
		else $error("no counter reset on power-up");
	c_fastlock_run: cover property (fastlock_active_o ##1 !fastlock_active_o);
	c_prescale_pulse: cover property (lock_detect_prescale_q && main_ld_cycle_o);
	c_powerup: cover property ($rose(powered));
	c_wide_mode: cover property (resolution_sel_i && den_hi_q != 10'h000);
endmodule

// file: sfr_regs.svh
// Serial word addresses, field positions and reset values of the synthesizer control words
`ifndef SFR_REGS_SVH
`define SFR_REGS_SVH

`define SFR_WORD_W 24
`define SFR_ADDR_MSB 3
`define SFR_ADDR_LSB 0
`define SFR_ADDR_DEN 4'hb
`define SFR_ADDR_FL 4'hd
`define SFR_ADDR_CTL 4'hf

`define SFR_DEN_HI_MSB 23
`define SFR_DEN_HI_LSB 14
`define SFR_DEN_HI_RST 10'h000

`define SFR_TOC_MSB 17
`define SFR_TOC_LSB 4
`define SFR_CPF_MSB 21
`define SFR_CPF_LSB 18
`define SFR_CSR_MSB 23
`define SFR_CSR_LSB 22
`define SFR_TOC_RST 14'h0000
`define SFR_CPF_RST 4'h0
`define SFR_CSR_RST 2'h0
`define SFR_TOC_MIN_TIMED 14'h0004
`define SFR_TOC_HIZ 14'h0000
`define SFR_TOC_MANUAL 14'h0001
`define SFR_TOC_LOW 14'h0002
`define SFR_TOC_HIGH 14'h0003

`define SFR_CTL_PRESCALE_BIT 13
`define SFR_CTL_AUX_RST_BIT 7
`define SFR_CTL_MAIN_RST_BIT 6
`define SFR_CTL_AUX_TRI_BIT 5
`define SFR_CTL_MAIN_TRI_BIT 4

`define SFR_PRESCALE_LAST 2'h3
`define SFR_CSR_OFF 2'h0
`define SFR_CSR_HALF 2'h1
`define SFR_CSR_QUARTER 2'h2
`define SFR_CSR_SHIFT_OFF 3'h0
`define SFR_CSR_SHIFT_HALF 3'h1
`define SFR_CSR_SHIFT_QUARTER 3'h2
`define SFR_CSR_SHIFT_SIXTEENTH 3'h4

`endif

// file: sfr_pkg.sv
// Types shared by the synthesizer control-word logic
package sfr_pkg;
	typedef enum logic [2:0] {
		PIN_HIZ,
		PIN_MANUAL,
		PIN_LOW,
		PIN_HIGH,
		PIN_FASTLOCK
	} sfr_pin_mode_t;

	typedef enum logic {
		FL_IDLE,
		FL_ACTIVE
	} sfr_fl_state_t;
endpackage

// file: sfr_serial_rx.sv
// Three-wire serial receiver: shifts in 24-bit words, presents each on the latch edge
`timescale 1ns/1ps
`include "sfr_regs.svh"
module sfr_serial_rx
	import sfr_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// Serial pins
	input wire logic ser_clk_i,
	input wire logic ser_data_i,
	input wire logic ser_le_i,
	// Received word
	output logic [`SFR_WORD_W-1:0] word_o,
	output logic word_valid_o
);
	logic [2:0] clk_sync_q;
	logic [2:0] le_sync_q;
	logic [1:0] data_sync_q;
	logic [`SFR_WORD_W-1:0] shift_q;
	logic [`SFR_WORD_W-1:0] word_q;
	logic word_valid_q;
	logic clk_rise;
	logic le_rise;

	// Two-stage synchronisers; stage 2 and 3 used for edge detection
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			clk_sync_q <= 3'h0;
			le_sync_q <= 3'h0;
			data_sync_q <= 2'h0;
		end else begin
			clk_sync_q <= {clk_sync_q[1:0], ser_clk_i};
			le_sync_q <= {le_sync_q[1:0], ser_le_i};
			data_sync_q <= {data_sync_q[0], ser_data_i};
		end
	end

	assign clk_rise = clk_sync_q[1] & ~clk_sync_q[2];
	assign le_rise = le_sync_q[1] & ~le_sync_q[2];

	// Most significant bit first
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			shift_q <= '0;
		end else if (clk_rise) begin
			shift_q <= {shift_q[`SFR_WORD_W-2:0], data_sync_q[1]};
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			word_q <= '0;
			word_valid_q <= 1'b0;
		end else begin
			word_valid_q <= le_rise;
			if (le_rise) begin
				word_q <= shift_q;
			end
		end
	end

	assign word_o = word_q;
	assign word_valid_o = word_valid_q;
endmodule

// file: sfr_host_model.sv
// Host controller model: builds and shifts serial programming words
`timescale 1ns/1ps
module sfr_host_model (
	// Clock
	input wire logic ref_clk_i,
	// Serial pins
	output logic ser_clk_o,
	output logic ser_data_o,
	output logic ser_le_o
);
	initial begin
		ser_clk_o = 1'b0;
		ser_data_o = 1'b0;
		ser_le_o = 1'b0;
	end

	function automatic logic [23:0] fl_word(logic [13:0] toc, logic [3:0] cpf, logic [1:0] cycle_slip_reduction);
		return {cycle_slip_reduction, cpf, toc, 4'hd};
	endfunction

	function automatic logic [23:0] ctl_word(logic pre, logic [3:0] rst_tri);
		return {10'h000, pre, 1'b0, 1'b1, 3'h0, rst_tri, 4'hf};
	endfunction

	// Upper denominator bits; zero below 4096 is the caller's job
	function automatic logic [23:0] den_word(logic [9:0] hi);
		return {hi, 10'h000, 4'hb};
	endfunction

	// Clock high for ph, low for ph+1 reference cycles; data line inverted after the frame
	task automatic send_word(input logic [23:0] w, input int ph);
		for (int i = 23; i >= 0; i--) begin
			@(negedge ref_clk_i);
			ser_data_o = w[i];
			repeat (ph) @(negedge ref_clk_i);
			ser_clk_o = 1'b1;
			repeat (ph) @(negedge ref_clk_i);
			ser_clk_o = 1'b0;
		end
		repeat (ph) @(negedge ref_clk_i);
		ser_data_o = ~w[0];
		ser_le_o = 1'b1;
		repeat (ph) @(negedge ref_clk_i);
		ser_le_o = 1'b0;
		repeat (ph + 2) @(negedge ref_clk_i);
	endtask
endmodule

// file: tb.sv
// Self-checking testbench of the synthesizer control-word block
`timescale 1ns/1ps
module tb;
	import sfr_pkg::*;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic ser_clk_i, ser_data_i, ser_le_i;
	logic resolution_sel_i = 1'b0;
	logic [11:0] den_low_i = 12'h000;
	logic pd_cycle_i = 1'b0;
	logic aux_pd_cycle_i = 1'b0;
	logic fastlock_start_i = 1'b0;
	logic sw_powerdown_i = 1'b0;
	logic chip_enable_i = 1'b1;
	logic [21:0] fractional_denominator_o;
	logic fastlock_active_o, force_fastlock_o, fastlock_indicator_pin_o, fastlock_indicator_pin_oe_o;
	logic [4:0] fastlock_pump_current_o;
	logic [2:0] cycle_slip_reduction_o;
	logic main_ld_cycle_o, aux_ld_cycle_o;
	logic main_counter_reset_o, aux_counter_reset_o, main_pump_tristate_o, aux_pump_tristate_o;
	int n_errors = 0;
	int total_checks = 0;
	int n_main = 0;
	int n_aux = 0;
	logic [13:0] t;
	logic [3:0] r;
	logic [9:0] hi;
	logic [11:0] lo;
	wire logic [3:0] rst_vec = {main_counter_reset_o, aux_counter_reset_o, main_pump_tristate_o, aux_pump_tristate_o};
	wire logic [3:0] pin_vec = {fastlock_indicator_pin_oe_o, fastlock_indicator_pin_o, force_fastlock_o,
		fastlock_active_o};

	sfr_host_model i_host (.ref_clk_i, .ser_clk_o(ser_clk_i), .ser_data_o(ser_data_i), .ser_le_o(ser_le_i));

	sfr_top i_dut (
		.ref_clk_i, .rst_i, .ser_clk_i, .ser_data_i, .ser_le_i, .resolution_sel_i, .den_low_i,
		.pd_cycle_i, .aux_pd_cycle_i, .fastlock_start_i, .sw_powerdown_i, .chip_enable_i,
		.fractional_denominator_o, .fastlock_active_o, .force_fastlock_o, .fastlock_indicator_pin_o,
		.fastlock_indicator_pin_oe_o, .fastlock_pump_current_o, .cycle_slip_reduction_o,
		.main_ld_cycle_o, .aux_ld_cycle_o, .main_counter_reset_o, .aux_counter_reset_o,
		.main_pump_tristate_o, .aux_pump_tristate_o
	);

	initial begin
		forever #50 ref_clk_i = ~ref_clk_i;
	end

	always @(negedge ref_clk_i) begin
		if (main_ld_cycle_o === 1'b1) begin
			n_main++;
		end
		if (aux_ld_cycle_o === 1'b1) begin
			n_aux++;
		end
	end

	function automatic logic [2:0] pin_exp(logic [1:0] m);
		case (m)
			2'h0: return 3'b000;
			2'h1: return 3'b101;
			2'h2: return 3'b100;
			default: return 3'b110;
		endcase
	endfunction

	function automatic logic [2:0] csr_exp(logic [1:0] c);
		return (c == 2'h3) ? 3'h4 : {1'b0, c};
	endfunction

	task automatic chk_den(input logic [21:0] got, input logic [21:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t denominator got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_out(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t output got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic pulse_start();
		@(negedge ref_clk_i);
		fastlock_start_i = 1'b1;
		@(negedge ref_clk_i);
		fastlock_start_i = 1'b0;
	endtask

	task automatic pd_burst(input int n, input logic both);
		for (int i = 0; i < n; i++) begin
			@(negedge ref_clk_i);
			pd_cycle_i = 1'b1;
			aux_pd_cycle_i = both;
			@(negedge ref_clk_i);
			pd_cycle_i = 1'b0;
			aux_pd_cycle_i = 1'b0;
		end
	endtask

	// Power down by software or chip enable, then count reset pulse cycles
	task automatic pwr_cycle(input logic use_ce);
		int seen;
		seen = 0;
		@(negedge ref_clk_i);
		chip_enable_i = ~use_ce;
		sw_powerdown_i = ~use_ce;
		repeat (6) @(negedge ref_clk_i);
		chip_enable_i = 1'b1;
		sw_powerdown_i = 1'b0;
		for (int i = 0; i < 12; i++) begin
			@(negedge ref_clk_i);
			if (rst_vec === 4'hf) begin
				seen++;
			end
		end
		chk_out(8'(seen), 8'd1);
	endtask

	// Bounds the whole run
	initial begin
		repeat (100000) @(posedge ref_clk_i);
		n_errors++;
		close_out();
	end

	initial begin
		void'($urandom(32'hf5c5));
		repeat (4) @(negedge ref_clk_i);
		rst_i = 1'b0;
		repeat (10) @(negedge ref_clk_i);
		chk_out(8'(fastlock_pump_current_o), 8'h01);
		chk_out(8'(rst_vec), 8'h00);
		$display("test reset done");
		for (int k = 0; k < 6; k++) begin
			hi = (k == 0) ? 10'h000 : 10'($urandom_range(1023, 1));
			lo = 12'($urandom);
			i_host.send_word(i_host.den_word(hi), 3);
			resolution_sel_i = k[0] | (k == 0);
			den_low_i = lo;
			repeat (3) @(negedge ref_clk_i);
			chk_den(fractional_denominator_o, resolution_sel_i ? {hi, lo} : {10'h000, lo});
		end
		$display("test denominator done");
		for (int k = 0; k < 2; k++) begin
			t = (k == 0) ? 14'h0004 : 14'($urandom_range(40, 5));
			i_host.send_word(i_host.fl_word(t, 4'h0, 2'h0), 3 + k);
			chk_out(8'(pin_vec), 8'h08);
			pulse_start();
			chk_out(8'(fastlock_active_o), 8'h01);
			pd_burst(2 * t - 1, 1'b0);
			chk_out(8'(pin_vec), 8'h0d);
			pd_burst(1, 1'b0);
			@(negedge ref_clk_i);
			chk_out(8'(fastlock_active_o), 8'h00);
		end
		// Time-out rewritten below four while running, no comparison cycles
		i_host.send_word(i_host.fl_word(14'h0020, 4'h0, 2'h0), 3);
		pulse_start();
		chk_out(8'(fastlock_active_o), 8'h01);
		i_host.send_word(i_host.fl_word(14'h0000, 4'h0, 2'h0), 3);
		chk_out(8'(fastlock_active_o), 8'h00);
		$display("test timed fastlock done");
		for (int m = 0; m < 4; m++) begin
			i_host.send_word(i_host.fl_word(14'(m), 4'h0, 2'h0), 3);
			pulse_start();
			repeat (2) @(negedge ref_clk_i);
			chk_out(8'(pin_vec), {4'h0, pin_exp(2'(m)), 1'b0});
		end
		$display("test pin modes done");
		for (int c = 0; c < 16; c++) begin
			i_host.send_word(i_host.fl_word(14'h0000, 4'(c), 2'(c)), 3);
			chk_out(8'(fastlock_pump_current_o), 8'(c + 1));
			chk_out(8'(cycle_slip_reduction_o), {5'h00, csr_exp(2'(c))});
		end
		$display("test pump and slip done");
		for (int p = 0; p < 2; p++) begin
			i_host.send_word(i_host.ctl_word(p[0], 4'h0), 3);
			n_main = 0;
			n_aux = 0;
			pd_burst(8, 1'b1);
			repeat (3) @(negedge ref_clk_i);
			chk_out(8'(n_main), (p == 1) ? 8'd2 : 8'd8);
			chk_out(8'(n_aux), 8'd8);
		end
		$display("test prescale done");
		for (int b = 0; b < 5; b++) begin
			r = (b < 4) ? 4'(1 << b) : 4'h0;
			i_host.send_word(i_host.ctl_word(1'b0, r), 3);
			chk_out(8'(rst_vec), {4'h0, r[2], r[3], r[2] | r[0], r[3] | r[1]});
		end
		$display("test counter resets done");
		pwr_cycle(1'b0);
		pwr_cycle(1'b1);
		$display("test power-up done");
		close_out();
	end
endmodule
